//--- src/wlbr_branch_unit.sv
module wlbr_branch_unit (
    // Command
    input wire logic [wlbr_pkg::OP_W-1:0] op,
    input wire logic branch_pred,
    // Loop state before and after
    input wlbr_pkg::wlbr_loop_type cur,
    output wlbr_pkg::wlbr_loop_type nxt,
    // Outcome
    output logic taken,
    output logic rotated
);
    import wlbr_pkg::*;

    // Loop branch decision, counter update and rotation
    always_comb begin
        logic new_bit;
        new_bit = 1'b0;
        nxt = cur;
        taken = 1'b0;
        rotated = 1'b0;
        case (op)
            OP_WTOP: begin
                // Loop count is never consulted here
                if (branch_pred) begin
                    taken = 1'b1;
                    rotated = 1'b1;
                end else if (cur.ec > EC_ONE) begin
                    taken = 1'b1;
                    rotated = 1'b1;
                    nxt.ec = cur.ec - EC_ONE;
                end else if (cur.ec == EC_ONE) begin
                    rotated = 1'b1;
                    nxt.ec = cur.ec - EC_ONE;
                end
                new_bit = 1'b0;
            end
            OP_CTOP: begin
                // Single-cycle continue decision feeds the first stage
                if (cur.lc != LC_RST) begin
                    taken = 1'b1;
                    rotated = 1'b1;
                    nxt.lc = cur.lc - LC_ONE;
                    new_bit = 1'b1;
                end else if (cur.ec > EC_ONE) begin
                    taken = 1'b1;
                    rotated = 1'b1;
                    nxt.ec = cur.ec - EC_ONE;
                end else if (cur.ec == EC_ONE) begin
                    rotated = 1'b1;
                    nxt.ec = cur.ec - EC_ONE;
                end
            end
            default: begin
                taken = 1'b0;
            end
        endcase
        // Shift stage predicates up and lower the rename base
        if (rotated) begin
            nxt.pred = {cur.pred[ROT_N-2:0], new_bit};
            nxt.rrb = wlbr_rrb_dec(cur.rrb);
        end
    end

endmodule

//--- src/wlbr_pkg.sv
package wlbr_pkg;

    // Widths of the loop state, the bus and the command code
    localparam int ROT_N = 48;
    localparam int RRB_W = 6;
    localparam int EC_W = 6;
    localparam int LC_W = 32;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int OP_W = 3;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADR_W-1:0] OFF_EC = 8'h04;
    localparam logic [ADR_W-1:0] OFF_LC = 8'h08;
    localparam logic [ADR_W-1:0] OFF_PRED_LO = 8'h0c;
    localparam logic [ADR_W-1:0] OFF_PRED_HI = 8'h10;
    localparam logic [ADR_W-1:0] OFF_RRB = 8'h14;
    localparam logic [ADR_W-1:0] OFF_MAP = 8'h18;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BP_BIT = 3;
    localparam int CMD_UNC_BIT = 4;
    localparam int CMD_TGT_LSB = 8;
    localparam int STAT_TAKEN_BIT = 0;
    localparam int STAT_ROT_BIT = 1;
    localparam int PRED_HI_W = ROT_N - DAT_W;

    // Command codes
    localparam logic [OP_W-1:0] OP_NONE = 3'h0;
    localparam logic [OP_W-1:0] OP_WTOP = 3'h1;
    localparam logic [OP_W-1:0] OP_CTOP = 3'h2;
    localparam logic [OP_W-1:0] OP_CMP = 3'h3;

    // Constants and reset values
    localparam logic [RRB_W-1:0] ROT_LAST = 6'h2f;
    localparam logic [EC_W-1:0] EC_ONE = 6'h01;
    localparam logic [LC_W-1:0] LC_ONE = 32'h0000_0001;
    localparam logic [EC_W-1:0] EC_RST = 6'h00;
    localparam logic [LC_W-1:0] LC_RST = 32'h0000_0000;
    localparam logic [ROT_N-1:0] PRED_RST = 48'h0000_0000_0000;
    localparam logic [RRB_W-1:0] RRB_RST = 6'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } wlbr_wb_req_type;

    typedef struct packed {
        logic [EC_W-1:0] ec;
        logic [LC_W-1:0] lc;
        logic [ROT_N-1:0] pred;
        logic [RRB_W-1:0] rrb;
    } wlbr_loop_type;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] rdat;
        wlbr_loop_type loop;
        logic taken;
        logic last_taken;
        logic last_rotated;
        logic [RRB_W-1:0] map_idx;
    } wlbr_state_type;

    // Rename base steps down, wrapping over the rotating file
    function automatic logic [RRB_W-1:0] wlbr_rrb_dec(input logic [RRB_W-1:0] rrb);
        return (rrb == RRB_RST) ? ROT_LAST : rrb - 6'h01;
    endfunction

    // Logical rotating index to physical slot under the rename base
    function automatic logic [RRB_W-1:0] wlbr_rename(input logic [RRB_W-1:0] idx,
                                                     input logic [RRB_W-1:0] rrb);
        logic [RRB_W:0] sum;
        sum = {1'b0, idx} + {1'b0, rrb};
        if (idx > ROT_LAST) begin
            return idx;
        end
        if (sum > {1'b0, ROT_LAST}) begin
            sum = sum - {1'b0, ROT_LAST} - 7'h01;
        end
        return sum[RRB_W-1:0];
    endfunction

endpackage

//--- src/wlbr_top.sv
// Functional notes
// - Registers are renamed against a rename base that each rotation decrements.
// - While branch, predicate zero: continue only if epilog counter above one; decrement.
// - While branch falling out still decrements epilog counter and rotates once.
// - Conditional compare with false result leaves its target predicate alone.
// - Unconditional compare always writes target, zero when condition fails.
// - Rotation moves each stage predicate into the next higher one.
// - Counted branch decides continue in one cycle, result into first stage predicate.
// - While branch ignores the loop count register entirely.
// - After a while branch rotation the first stage predicate is zero.
//
// Implementation choices: the address map and the Wishbone register port.
module wlbr_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wlbr_pkg::wlbr_wb_req_type wb_req,
    output logic wb_ack,
    output logic [wlbr_pkg::DAT_W-1:0] wb_dat,
    // Branch outcome
    output logic branch_taken,
    output logic [wlbr_pkg::RRB_W-1:0] rename_base
);
    import wlbr_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n_q;
    wlbr_state_type st;
    wlbr_state_type next_st;
    wlbr_loop_type bu_nxt;
    logic bu_taken;
    logic bu_rot;
    logic req_live;
    logic do_cmd;
    logic [OP_W-1:0] cmd_op;
    logic cmd_bp;
    logic cmd_unc;
    logic [RRB_W-1:0] cmd_tgt;

    // Byte-lane merge of a write into a word
    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_w,
                                               input logic [DAT_W-1:0] new_w,
                                               input logic [SEL_W-1:0] sel);
        logic [DAT_W-1:0] res;
        res = old_w;
        for (int i = 0; i < SEL_W; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_q = rst_sync[1];

    // Command decode
    assign req_live = wb_req.cyc & wb_req.stb;
    assign do_cmd = req_live & st.ack & wb_req.we & (wb_req.adr == OFF_CMD);
    assign cmd_op = wb_req.dat[CMD_OP_LSB +: OP_W];
    assign cmd_bp = wb_req.dat[CMD_BP_BIT];
    assign cmd_unc = wb_req.dat[CMD_UNC_BIT];
    assign cmd_tgt = wb_req.dat[CMD_TGT_LSB +: RRB_W];

    wlbr_branch_unit u_branch (
        .op(cmd_op),
        .branch_pred(cmd_bp),
        .cur(st.loop),
        .nxt(bu_nxt),
        .taken(bu_taken),
        .rotated(bu_rot)
    );

    // Bus answer, register writes and command execution
    always_comb begin
        logic [DAT_W-1:0] rd;
        logic [DAT_W-1:0] wtmp;
        rd = '0;
        wtmp = '0;
        next_st = st;
        next_st.ack = 1'b0;
        next_st.taken = 1'b0;
        // Read data captured as ack rises, held for the ack cycle
        case (wb_req.adr)
            OFF_CMD: begin
                rd[STAT_TAKEN_BIT] = st.last_taken;
                rd[STAT_ROT_BIT] = st.last_rotated;
            end
            OFF_EC: rd[EC_W-1:0] = st.loop.ec;
            OFF_LC: rd = st.loop.lc;
            OFF_PRED_LO: rd = st.loop.pred[DAT_W-1:0];
            OFF_PRED_HI: rd[PRED_HI_W-1:0] = st.loop.pred[ROT_N-1:DAT_W];
            OFF_RRB: rd[RRB_W-1:0] = st.loop.rrb;
            OFF_MAP: rd[RRB_W-1:0] = wlbr_rename(st.map_idx, st.loop.rrb);
            default: rd = '0;
        endcase
        if (req_live && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdat = rd;
        end
        // Writes take effect at the edge where the master sees ack
        if (req_live && st.ack && wb_req.we) begin
            case (wb_req.adr)
                OFF_CMD: begin
                    if (cmd_op == OP_WTOP || cmd_op == OP_CTOP) begin
                        next_st.loop = bu_nxt;
                        next_st.taken = bu_taken;
                        next_st.last_taken = bu_taken;
                        next_st.last_rotated = bu_rot;
                    end else if (cmd_op == OP_CMP && cmd_tgt <= ROT_LAST) begin
                        if (cmd_unc) begin
                            next_st.loop.pred[cmd_tgt] = cmd_bp;
                        end else if (cmd_bp) begin
                            next_st.loop.pred[cmd_tgt] = 1'b1;
                        end
                    end
                end
                OFF_EC: begin
                    wtmp = merge({{(DAT_W-EC_W){1'b0}}, st.loop.ec}, wb_req.dat, wb_req.sel);
                    next_st.loop.ec = wtmp[EC_W-1:0];
                end
                OFF_LC: next_st.loop.lc = merge(st.loop.lc, wb_req.dat, wb_req.sel);
                OFF_PRED_LO: begin
                    wtmp = merge(st.loop.pred[DAT_W-1:0], wb_req.dat, wb_req.sel);
                    next_st.loop.pred[DAT_W-1:0] = wtmp;
                end
                OFF_PRED_HI: begin
                    wtmp = merge({{(DAT_W-PRED_HI_W){1'b0}}, st.loop.pred[ROT_N-1:DAT_W]},
                                 wb_req.dat, wb_req.sel);
                    next_st.loop.pred[ROT_N-1:DAT_W] = wtmp[PRED_HI_W-1:0];
                end
                OFF_RRB: begin
                    if (wb_req.dat[RRB_W-1:0] <= ROT_LAST) begin
                        next_st.loop.rrb = wb_req.dat[RRB_W-1:0];
                    end
                end
                OFF_MAP: next_st.map_idx = wb_req.dat[RRB_W-1:0];
                default: next_st.ack = 1'b0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st.ack <= 1'b0;
            st.rdat <= '0;
            st.loop.ec <= EC_RST;
            st.loop.lc <= LC_RST;
            st.loop.pred <= PRED_RST;
            st.loop.rrb <= RRB_RST;
            st.taken <= 1'b0;
            st.last_taken <= 1'b0;
            st.last_rotated <= 1'b0;
            st.map_idx <= RRB_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign wb_ack = st.ack;
    assign wb_dat = st.rdat;
    assign branch_taken = st.taken;
    assign rename_base = st.loop.rrb;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    // While and counted branch, rotation, compare and bus ack behaviour
    wtop_loop_back_a: assert property (
        do_cmd && cmd_op == OP_WTOP && cmd_bp |=>
        st.taken && st.loop.ec == $past(st.loop.ec) &&
        st.loop.rrb == wlbr_rrb_dec($past(st.loop.rrb)))
        else $error("while branch with predicate one did not loop back unchanged");

    wtop_epilog_continue_a: assert property (
        do_cmd && cmd_op == OP_WTOP && !cmd_bp && st.loop.ec > EC_ONE |=>
        st.taken && st.loop.ec == $past(st.loop.ec) - EC_ONE)
        else $error("while branch epilog continue wrong");

    wtop_exit_rotate_a: assert property (
        do_cmd && cmd_op == OP_WTOP && !cmd_bp && st.loop.ec == EC_ONE |=>
        !st.taken && st.loop.ec == EC_RST && st.last_rotated &&
        st.loop.rrb == wlbr_rrb_dec($past(st.loop.rrb)))
        else $error("while branch exit missed final rotation");

    wtop_stage_clear_a: assert property (
        do_cmd && cmd_op == OP_WTOP && (cmd_bp || st.loop.ec != EC_RST) |=>
        !st.loop.pred[0])
        else $error("first stage predicate not cleared by while branch");

    wtop_no_count_a: assert property (
        do_cmd && cmd_op == OP_WTOP |=> st.loop.lc == $past(st.loop.lc))
        else $error("while branch touched loop count");

    rotate_shift_a: assert property (
        do_cmd ##1 st.last_rotated && $changed(st.loop.rrb) |->
        st.loop.pred[ROT_N-1:1] == $past(st.loop.pred[ROT_N-2:0]))
        else $error("stage predicates not shifted up on rotation");

    ctop_continue_a: assert property (
        do_cmd && cmd_op == OP_CTOP && st.loop.lc != LC_RST |=>
        st.loop.pred[0] && st.taken && st.loop.lc == $past(st.loop.lc) - LC_ONE)
        else $error("counted branch did not set first stage predicate");

    cmp_cond_hold_a: assert property (
        do_cmd && cmd_op == OP_CMP && !cmd_unc && !cmd_bp |=>
        st.loop.pred == $past(st.loop.pred))
        else $error("conditional compare changed predicates on false");

    cmp_unc_zero_a: assert property (
        do_cmd && cmd_op == OP_CMP && cmd_unc && !cmd_bp && cmd_tgt <= ROT_LAST |=>
        !st.loop.pred[$past(cmd_tgt)])
        else $error("unconditional compare did not write zero");

    rename_step_a: assert property (
        do_cmd && (cmd_op == OP_WTOP || cmd_op == OP_CTOP) ##1 st.last_rotated |->
        st.loop.rrb == wlbr_rrb_dec($past(st.loop.rrb)))
        else $error("rename base not decremented on rotation");

    bus_ack_a: assert property (
        req_live && !st.ack |=> st.ack ##1 !st.ack)
        else $error("bus ack not a single cycle");

    // Counted branch epilog and exit paths
    ctop_epilog_a: assert property (
        do_cmd && cmd_op == OP_CTOP && st.loop.lc == LC_RST && st.loop.ec > EC_ONE |=>
        st.taken && !st.loop.pred[0] && st.loop.ec == $past(st.loop.ec) - EC_ONE)
        else $error("counted branch epilog step wrong");

    ctop_exit_a: assert property (
        do_cmd && cmd_op == OP_CTOP && st.loop.lc == LC_RST && st.loop.ec == EC_ONE |=>
        !st.taken && st.last_rotated && st.loop.ec == EC_RST)
        else $error("counted branch exit missed final rotation");

    // An empty epilog counter freezes the loop state on a while branch with predicate zero
    ec_empty_idle_a: assert property (
        do_cmd && cmd_op == OP_WTOP && !cmd_bp && st.loop.ec == EC_RST |=>
        !st.taken && !st.last_rotated && st.loop == $past(st.loop))
        else $error("while branch moved state with empty epilog counter");

    // Compare commands never rotate, branch or reach past the file
    cmp_no_rotate_a: assert property (
        do_cmd && cmd_op == OP_CMP |=>
        !st.taken && st.loop.rrb == $past(st.loop.rrb) && st.loop.ec == $past(st.loop.ec))
        else $error("compare command rotated or branched");

    cmp_cond_set_a: assert property (
        do_cmd && cmd_op == OP_CMP && !cmd_unc && cmd_bp && cmd_tgt <= ROT_LAST |=>
        st.loop.pred[$past(cmd_tgt)])
        else $error("conditional compare did not set its target");

    cmp_unc_one_a: assert property (
        do_cmd && cmd_op == OP_CMP && cmd_unc && cmd_bp && cmd_tgt <= ROT_LAST |=>
        st.loop.pred[$past(cmd_tgt)])
        else $error("unconditional compare did not write one");

    cmp_tgt_range_a: assert property (
        do_cmd && cmd_op == OP_CMP && cmd_tgt > ROT_LAST |=>
        st.loop.pred == $past(st.loop.pred))
        else $error("compare with out of range target changed predicates");

    // Rename base stays inside the rotating file
    rrb_range_a: assert property (
        st.loop.rrb <= ROT_LAST)
        else $error("rename base left the rotating file");

    // Branch pulse, status and held read data
    taken_pulse_a: assert property (
        st.taken |=> !st.taken)
        else $error("branch taken held longer than one cycle");

    status_track_a: assert property (
        do_cmd && (cmd_op == OP_WTOP || cmd_op == OP_CTOP) |=> st.last_taken == st.taken)
        else $error("status bit disagrees with branch pulse");

    rdat_hold_a: assert property (
        st.ack |=> $stable(st.rdat))
        else $error("read data changed right after ack");

    // Writes to places with no register leave the loop state alone
    unmapped_write_a: assert property (
        req_live && st.ack && wb_req.we && wb_req.adr > OFF_MAP |=>
        st.loop == $past(st.loop))
        else $error("write to an unmapped place changed loop state");

    // Main scenarios reached
    wtop_kernel_c: cover property (do_cmd && cmd_op == OP_WTOP && cmd_bp);
    wtop_exit_c: cover property (do_cmd && cmd_op == OP_WTOP && !cmd_bp && st.loop.ec == EC_ONE);
    ctop_run_c: cover property (do_cmd && cmd_op == OP_CTOP && st.loop.lc != LC_RST);
    cmp_cond_c: cover property (do_cmd && cmd_op == OP_CMP && !cmd_unc && cmd_bp);
    ctop_epilog_c: cover property (do_cmd && cmd_op == OP_CTOP && st.loop.lc == LC_RST &&
        st.loop.ec > EC_ONE);

endmodule

//--- verif/wlbr_top_tb_top.sv
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); end end

module wlbr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wlbr_pkg::*;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    wlbr_wb_req_type wb_req = '0;
    logic wb_ack;
    logic [DAT_W-1:0] wb_dat;
    logic branch_taken;
    logic [RRB_W-1:0] rename_base;
    int fail_count = 0;
    int tests_run = 0;
    logic [DAT_W-1:0] rd;
    logic bt;
    logic [EC_W-1:0] m_ec;
    logic [LC_W-1:0] m_lc;
    logic [ROT_N-1:0] m_pred;
    logic [RRB_W-1:0] m_rrb;
    logic m_taken;
    logic m_rot;

    // Device under test
    wlbr_top i_wlbr_top (
        .clk(clk),
        .resetn(resetn),
        .wb_req(wb_req),
        .wb_ack(wb_ack),
        .wb_dat(wb_dat),
        .branch_taken(branch_taken),
        .rename_base(rename_base)
    );

    // Free running clock
    always #10 clk = ~clk;

    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One classic cycle; holds the request until ack is seen, then one idle cycle
    task automatic bus(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
        int n;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        n = 0;
        // Ack and read data are taken at the rising edge that sees ack high
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        rd = wb_dat;
        wb_req <= '0;
        @(negedge clk);
        bt = branch_taken;
    endtask

    task automatic wr(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
        bus(1'b1, adr, dat);
    endtask

    task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
        bus(1'b0, adr, 32'h0);
        `CHK(rd, exp)
    endtask

    // Expected effect of a loop branch on the model state
    function automatic void model_branch(input logic [OP_W-1:0] op, input logic bp);
        logic p0;
        p0 = 1'b0;
        m_taken = 1'b0;
        m_rot = 1'b0;
        if (op == OP_CTOP && m_lc != 0) begin
            m_lc = m_lc - 32'h1;
            p0 = 1'b1;
            m_taken = 1'b1;
            m_rot = 1'b1;
        end else if (op == OP_WTOP && bp) begin
            m_taken = 1'b1;
            m_rot = 1'b1;
        end else if (m_ec > 1) begin
            m_ec = m_ec - 6'h01;
            m_taken = 1'b1;
            m_rot = 1'b1;
        end else if (m_ec == 1) begin
            m_ec = 6'h00;
            m_rot = 1'b1;
        end
        if (m_rot) begin
            m_pred = {m_pred[ROT_N-2:0], p0};
            m_rrb = (m_rrb == 0) ? ROT_LAST : m_rrb - 6'h01;
        end
    endfunction

    task automatic load_state;
        wr(OFF_EC, {26'h0, m_ec});
        wr(OFF_LC, m_lc);
        wr(OFF_PRED_LO, m_pred[31:0]);
        wr(OFF_PRED_HI, {16'h0, m_pred[47:32]});
        wr(OFF_RRB, {26'h0, m_rrb});
    endtask

    task automatic check_state;
        rd_chk(OFF_EC, {26'h0, m_ec});
        rd_chk(OFF_LC, m_lc);
        rd_chk(OFF_PRED_LO, m_pred[31:0]);
        rd_chk(OFF_PRED_HI, {16'h0, m_pred[47:32]});
        rd_chk(OFF_RRB, {26'h0, m_rrb});
        `CHK(rename_base, m_rrb)
    endtask

    // Main sequence
    initial begin
        logic [31:0] r1;
        logic [31:0] r2;
        logic [OP_W-1:0] op;
        logic bp;
        logic unc;
        logic [RRB_W-1:0] tgt;
        void'($urandom(32'h3e00));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        m_ec = EC_RST;
        m_lc = LC_RST;
        m_pred = PRED_RST;
        m_rrb = RRB_RST;
        check_state;
        // Unmapped place and out-of-range rename base are ignored
        wr(8'h1c, 32'h5a5a_a5a5);
        rd_chk(8'h1c, 32'h0);
        wr(OFF_RRB, 32'h30);
        check_state;
        // Loop branches over random state, small epilog counts first
        for (int i = 0; i < 60; i++) begin
            r1 = $urandom;
            r2 = $urandom;
            m_ec = (i < 12) ? 6'(i % 3) : r1[5:0];
            m_lc = (r2[1:0] == 2'h0) ? 32'h0 : $urandom;
            m_pred = {r1[31:16], $urandom};
            m_rrb = (i % 10 == 0) ? 6'h00 : 6'(r2[15:8] % 48);
            op = r2[20] ? OP_WTOP : OP_CTOP;
            bp = r2[21];
            load_state;
            wr(OFF_CMD, {27'h0, 1'b0, bp, op});
            model_branch(op, bp);
            `CHK(bt, m_taken)
            rd_chk(OFF_CMD, {30'h0, m_rot, m_taken});
            check_state;
        end
        // Conditional and unconditional compares
        for (int i = 0; i < 40; i++) begin
            r1 = $urandom;
            tgt = 6'(r1[15:8] % 48);
            unc = r1[0];
            bp = r1[1];
            m_pred = {r1[31:16], $urandom};
            wr(OFF_PRED_LO, m_pred[31:0]);
            wr(OFF_PRED_HI, {16'h0, m_pred[47:32]});
            wr(OFF_CMD, {18'h0, tgt, 3'h0, unc, bp, OP_CMP});
            if (unc || bp) begin
                m_pred[tgt] = bp;
            end
            rd_chk(OFF_PRED_LO, m_pred[31:0]);
            rd_chk(OFF_PRED_HI, {16'h0, m_pred[47:32]});
        end
        // Idle and unknown codes, out-of-range compare target: acked, no effect
        wr(OFF_CMD, 32'h0);
        wr(OFF_CMD, {29'h0, 3'h5});
        wr(OFF_CMD, {18'h0, 6'h3a, 3'h0, 1'b1, 1'b0, OP_CMP});
        rd_chk(OFF_CMD, {30'h0, m_rot, m_taken});
        check_state;
        // Renaming against the current base
        for (int i = 0; i < 12; i++) begin
            r1 = $urandom;
            tgt = (i == 0) ? 6'h2f : r1[5:0];
            rd = 32'(tgt > ROT_LAST ? tgt : (tgt + m_rrb) % 48);
            r2 = rd;
            wr(OFF_MAP, {26'h0, tgt});
            rd_chk(OFF_MAP, r2);
        end
        // Reset in mid-run returns every register to its reset value
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        m_ec = EC_RST;
        m_lc = LC_RST;
        m_pred = PRED_RST;
        m_rrb = RRB_RST;
        check_state;
        rd_chk(OFF_CMD, 32'h0);
        rd_chk(OFF_MAP, 32'h0);
        wrap_up();
    end
endmodule
